// ---- verilog/sph_pkg.sv ----
// constants and register map of the strobed handshake parallel port
package sph_pkg;
  // ------------------------------------------------------------
  // bus and data widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PORT_W = 8;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PORT_B_DATA = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PORTC = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LATCH = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_DIR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h1C;
  // ------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------
  localparam int CTL_FLAG = 7;
  localparam int CTL_IRQEN = 6;
  localparam int CTL_ODRAIN = 5;
  localparam int CTL_HANDSHAKE_SELECT = 4;
  localparam int CTL_DIR = 3;
  localparam int CTL_PULSE = 2;
  localparam int CTL_EDGE = 1;
  localparam int CTL_INV = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // ------------------------------------------------------------
  // mode, status and mask fields
  // ------------------------------------------------------------
  localparam int MODE_SINGLE = 0;
  localparam int MODE_CPUMASK = 1;
  localparam logic [1:0] MODE_RST = 2'h3;
  localparam int EVT_W = 2;
  localparam int EVT_EDGE = 0;
  localparam int EVT_STRDONE = 1;
  localparam logic [EVT_W-1:0] EVT_RST = 2'h0;
  // ------------------------------------------------------------
  // timing: E clock as a divided rate of core_clk
  // ------------------------------------------------------------
  localparam int CORE_MHZ = 25;
  localparam int E_MHZ_X8 = 25;
  localparam int E_DIV = (CORE_MHZ * 8 + E_MHZ_X8 - 1) / E_MHZ_X8;
  localparam int OUTPUT_STROBE_PULSE_E = 2;
  localparam int OUTPUT_STROBE_PULSE_CYC = OUTPUT_STROBE_PULSE_E * E_DIV;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- verilog/sph_strobe_if.sv ----
// link between the port controller and the output strobe generator
`timescale 1ns/10ps
interface sph_strobe_if;
  logic enable;
  logic fire;
  logic hold;
  logic release_;
  logic invert;
  logic active;
  logic strobePin;
  logic done;
  modport gen (input enable, input fire, input hold, input release_, input invert,
    output active, output strobePin, output done);
  modport ctl (output enable, output fire, output hold, output release_, output invert,
    input active, input strobePin, input done);
endinterface

// ---- verilog/sph_strobe_gen.sv ----
// output strobe generator: timed pulse or interlocked level
`timescale 1ns/10ps
module sph_strobe_gen import sph_pkg::*; #(
  parameter int PULSE_CYC = OUTPUT_STROBE_PULSE_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // controller side
  sph_strobe_if.gen sif
);
  localparam int CW = $clog2(PULSE_CYC + 1);

  generate
    if (PULSE_CYC < 1) begin : g_bad
      $error("pulse length must be at least one cycle");
    end
  endgenerate

  logic activeQ, activeD;
  logic pinQ, pinD;
  logic doneQ, doneD;
  logic [CW-1:0] cntQ, cntD;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    activeD = activeQ;
    cntD = cntQ;
    doneD = 1'b0;
    if (!sif.enable) begin
      activeD = 1'b0;
      cntD = '0;
    end else if (sif.fire) begin
      activeD = 1'b1;
      cntD = sif.hold ? '0 : CW'(PULSE_CYC);
    end else if (activeQ) begin
      if (sif.hold) begin
        if (sif.release_) begin
          activeD = 1'b0;
          doneD = 1'b1;
        end
      end else begin
        if (cntQ <= CW'(1)) begin
          activeD = 1'b0;
          doneD = 1'b1;
          cntD = '0;
        end else begin
          cntD = cntQ - CW'(1);
        end
      end
    end
    pinD = sif.invert ? activeD : ~activeD;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      activeQ <= 1'b0;
      cntQ <= '0;
      doneQ <= 1'b0;
      pinQ <= 1'b1;
    end else begin
      activeQ <= activeD;
      cntQ <= cntD;
      doneQ <= doneD;
      pinQ <= pinD;
    end
  end

  assign sif.active = activeQ;
  assign sif.strobePin = pinQ;
  assign sif.done = doneQ;
endmodule // sph_strobe_gen

// ---- verilog/sph_parallel_io.sv ----
// strobed and full-handshake parallel port with an AXI4-Lite register slave
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
module sph_parallel_io import sph_pkg::*; #(
  parameter int PULSE_CYC = OUTPUT_STROBE_PULSE_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // strobes
  input wire logic inputStrobe,
  output logic outputStrobe,
  // port b
  output logic [PORT_W-1:0] portBOut,
  // port c
  input wire logic [PORT_W-1:0] portCIn,
  output logic [PORT_W-1:0] portCOut,
  output logic [PORT_W-1:0] portCOeN,
  // interrupt
  output logic irq
);
  generate
    if (PORT_W != 8 || PULSE_CYC < 1) begin : g_bad
      $error("unsupported port width or pulse length");
    end
  endgenerate

  sph_strobe_if sif ();

  sph_strobe_gen #(.PULSE_CYC(PULSE_CYC)) u_strobe (
    .core_clk(core_clk),
    .srst(srst),
    .sif(sif)
  );

  logic [7:0] ctrlQ, ctrlD;
  logic [1:0] modeQ, modeD;
  logic [PORT_W-1:0] portBQ, portBD, portCQ, portCD, latchQ, latchD, dirQ, dirD;
  logic [EVT_W-1:0] evtQ, evtD, maskQ, maskD;
  logic armQ, armD, strPrevQ;
  logic bvalidQ, bvalidD, rvalidQ, rvalidD;
  logic [1:0] brespQ, brespD, rrespQ, rrespD;
  logic [DATA_W-1:0] rdataQ, rdataD;
  logic [PORT_W-1:0] pcOutQ, pcOutD, pcOeNQ, pcOeND;
  logic wrEn, rdEn, wrLane0, single, handshake_select, outHs, edgeHit, forceOut;

  // ------------------------------------------------------------
  // decode of mode and strobe edge
  // ------------------------------------------------------------
  assign wrEn = s_axi_awvalid & s_axi_wvalid & ~bvalidQ;
  assign rdEn = s_axi_arvalid & ~rvalidQ;
  assign wrLane0 = wrEn & s_axi_wstrb[0];
  assign single = modeQ[MODE_SINGLE];
  assign handshake_select = ctrlQ[CTL_HANDSHAKE_SELECT];
  assign outHs = handshake_select & ctrlQ[CTL_DIR];
  assign edgeHit = single & (ctrlQ[CTL_EDGE] ? (inputStrobe & ~strPrevQ) : (~inputStrobe & strPrevQ));
  // active level forces port C out
  assign forceOut = single & outHs & (inputStrobe != ctrlQ[CTL_EDGE]);

  // ------------------------------------------------------------
  // registers and bus side effects
  // ------------------------------------------------------------
  always_comb begin
    ctrlD = ctrlQ;
    modeD = modeQ;
    portBD = portBQ;
    portCD = portCQ;
    latchD = latchQ;
    dirD = dirQ;
    maskD = maskQ;
    evtD = evtQ;
    armD = armQ;
    bvalidD = bvalidQ & ~s_axi_bready;
    brespD = brespQ;
    rvalidD = rvalidQ & ~s_axi_rready;
    rrespD = rrespQ;
    rdataD = rdataQ;
    sif.fire = 1'b0;
    if (wrEn) begin
      bvalidD = 1'b1;
      brespD = RESP_OKAY;
      case (s_axi_awaddr)
        OFS_CTRL: begin
          if (s_axi_wstrb[0]) begin
            ctrlD[CTL_IRQEN:0] = s_axi_wdata[CTL_IRQEN:0];
            // ready raised on entering input handshake
            if (s_axi_wdata[CTL_HANDSHAKE_SELECT] && !s_axi_wdata[CTL_DIR] && !(handshake_select && !outHs)) begin
              sif.fire = single;
            end
          end
        end
        OFS_PORT_B_DATA: begin
          if (s_axi_wstrb[0]) begin
            portBD = s_axi_wdata[PORT_W-1:0];
            // strobe on port B write, simple mode; independent of port C
            sif.fire = single & ~handshake_select;
          end
        end
        OFS_PORTC: if (s_axi_wstrb[0]) portCD = s_axi_wdata[PORT_W-1:0];
        OFS_LATCH: begin
          if (s_axi_wstrb[0]) begin
            latchD = s_axi_wdata[PORT_W-1:0];
            sif.fire = single & outHs;
            // write clears flag in output handshake
            if (outHs && armQ) begin
              ctrlD[CTL_FLAG] = 1'b0;
              armD = 1'b0;
            end
          end
        end
        OFS_DIR: if (s_axi_wstrb[0]) dirD = s_axi_wdata[PORT_W-1:0];
        OFS_STAT: if (s_axi_wstrb[0]) evtD = evtQ & ~s_axi_wdata[EVT_W-1:0];
        OFS_MASK: if (s_axi_wstrb[0]) maskD = s_axi_wdata[EVT_W-1:0];
        OFS_MODE: if (s_axi_wstrb[0]) modeD = s_axi_wdata[1:0];
        default: brespD = RESP_SLVERR;
      endcase
    end
    if (rdEn) begin
      rvalidD = 1'b1;
      rrespD = RESP_OKAY;
      rdataD = '0;
      case (s_axi_araddr)
        OFS_CTRL: begin
          rdataD[7:0] = ctrlQ;
          // arm on read with flag set
          if (ctrlQ[CTL_FLAG]) armD = 1'b1;
        end
        OFS_PORT_B_DATA: rdataD[PORT_W-1:0] = portBQ;
        // pin levels stay readable as plain I/O; static inputs
        OFS_PORTC: rdataD[PORT_W-1:0] = portCIn;
        OFS_LATCH: begin
          rdataD[PORT_W-1:0] = latchQ;
          if (single && handshake_select && !outHs) sif.fire = 1'b1;
          // read clears flag outside output handshake
          if (!outHs && armQ) begin
            ctrlD[CTL_FLAG] = 1'b0;
            armD = 1'b0;
          end
        end
        OFS_DIR: rdataD[PORT_W-1:0] = dirQ;
        OFS_STAT: rdataD[EVT_W-1:0] = evtQ;
        OFS_MASK: rdataD[EVT_W-1:0] = maskQ;
        OFS_MODE: rdataD[1:0] = modeQ;
        default: rrespD = RESP_SLVERR;
      endcase
    end
    // capture on strobe edge; input handshake capture
    if (edgeHit && !outHs) latchD = portCIn;
    if (edgeHit) begin
      ctrlD[CTL_FLAG] = 1'b1;
      evtD[EVT_EDGE] = 1'b1;
    end
    if (sif.done) evtD[EVT_STRDONE] = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrlQ <= CTRL_RST;
      modeQ <= MODE_RST;
      portBQ <= '0;
      portCQ <= '0;
      latchQ <= '0;
      dirQ <= '0;
      maskQ <= EVT_RST;
      evtQ <= EVT_RST;
      armQ <= 1'b0;
      strPrevQ <= 1'b1;
      bvalidQ <= 1'b0;
      brespQ <= RESP_OKAY;
      rvalidQ <= 1'b0;
      rrespQ <= RESP_OKAY;
      rdataQ <= '0;
    end else begin
      ctrlQ <= ctrlD;
      modeQ <= modeD;
      portBQ <= portBD;
      portCQ <= portCD;
      latchQ <= latchD;
      dirQ <= dirD;
      maskQ <= maskD;
      evtQ <= evtD;
      armQ <= armD;
      strPrevQ <= inputStrobe;
      bvalidQ <= bvalidD;
      brespQ <= brespD;
      rvalidQ <= rvalidD;
      rrespQ <= rrespD;
      rdataQ <= rdataD;
    end
  end

  // ------------------------------------------------------------
  // strobe generator control
  // ------------------------------------------------------------
  assign sif.enable = single;
  assign sif.hold = handshake_select & ~ctrlQ[CTL_PULSE];
  // capture edge negates ready; edge ends interlock
  assign sif.release_ = edgeHit & handshake_select;
  assign sif.invert = ctrlQ[CTL_INV];

  // ------------------------------------------------------------
  // port c drivers
  // ------------------------------------------------------------
  always_comb begin
    // all lines driven while forced except lines at 1 under open drain; no static inputs then
    pcOutD = outHs && single ? latchQ : portCQ;
    pcOeND = ~(dirQ | {PORT_W{forceOut}});
    // open drain drives only zeros
    if (ctrlQ[CTL_ODRAIN]) pcOeND = pcOeND | pcOutD;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pcOutQ <= '0;
      pcOeNQ <= '1;
    end else begin
      pcOutQ <= pcOutD;
      pcOeNQ <= pcOeND;
    end
  end

  assign portCOut = pcOutQ;
  assign portCOeN = pcOeNQ;
  assign portBOut = portBQ;
  assign outputStrobe = sif.strobePin;
  assign s_axi_awready = wrEn;
  assign s_axi_wready = wrEn;
  assign s_axi_bvalid = bvalidQ;
  assign s_axi_bresp = brespQ;
  assign s_axi_arready = ~rvalidQ;
  assign s_axi_rvalid = rvalidQ;
  assign s_axi_rresp = rrespQ;
  assign s_axi_rdata = rdataQ;
  // flag irq gated by enable and cpu mask
  assign irq = (ctrlQ[CTL_FLAG] & ctrlQ[CTL_IRQEN] & ~modeQ[MODE_CPUMASK]) | (|(evtQ & maskQ));

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // timed run length of the strobe
  int actRun;
  always_ff @(posedge core_clk) begin
    if (srst || !sif.active || sif.fire || sif.hold) begin
      actRun <= 0;
    end else begin
      actRun <= actRun + 1;
    end
  end
  property p_pulse_len;
    $fell(sif.active) && $past(sif.enable) && !$past(sif.hold) |-> actRun == PULSE_CYC;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("strobe pulse length wrong");
  property p_polarity;
    ##1 (outputStrobe == (ctrlQ[CTL_INV] ? sif.active : ~sif.active)) || $changed(ctrlQ[CTL_INV]);
  endproperty
  a_polarity: assert property (p_polarity) else $error("strobe polarity wrong");
  property p_capture;
    edgeHit && !outHs |=> latchQ == $past(portCIn);
  endproperty
  a_capture: assert property (p_capture) else $error("port C not captured");
  property p_port_b_data_fire;
    wrLane0 && s_axi_awaddr == OFS_PORT_B_DATA && single && !handshake_select |=> sif.active;
  endproperty
  a_port_b_data_fire: assert property (p_port_b_data_fire) else $error("no strobe on port B write");
  property p_single;
    !single |=> !sif.active && !ctrlD[CTL_FLAG] || ctrlQ[CTL_FLAG];
  endproperty
  a_single: assert property (p_single) else $error("strobe active outside single-chip");
  property p_ready_drop;
    edgeHit && handshake_select && !outHs && !ctrlQ[CTL_PULSE] && !sif.fire |=> !sif.active;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready not negated");
  property p_latch_wr;
    wrLane0 && s_axi_awaddr == OFS_LATCH && single && outHs |=> sif.active && outputStrobe == ctrlQ[CTL_INV];
  endproperty
  a_latch_wr: assert property (p_latch_wr) else $error("no strobe on latch write");
  property p_force;
    forceOut |=> pcOeNQ == ($past(ctrlQ[CTL_ODRAIN]) ? $past(pcOutD) : '0);
  endproperty
  a_force: assert property (p_force) else $error("port C not forced out");
  property p_flag_set;
    edgeHit |=> ctrlQ[CTL_FLAG] && evtQ[EVT_EDGE];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag lost on edge");
  property p_irq;
    ctrlQ[CTL_FLAG] && ctrlQ[CTL_IRQEN] && !modeQ[MODE_CPUMASK] |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  c_simple: cover property (single && !handshake_select && wrLane0 && s_axi_awaddr == OFS_PORT_B_DATA);
  c_in_hs: cover property (single && handshake_select && !outHs && edgeHit ##[1:50] sif.fire);
  c_out_hs: cover property (single && outHs && sif.fire ##[1:50] edgeHit);
endmodule // sph_parallel_io

// ---- testbench/sph_ext_system.sv ----
// external system model: drives the input strobe and its share of the port c wires
`timescale 1ns/10ps
module sph_ext_system import sph_pkg::*; (
  // clock
  input wire logic core_clk,
  // port c wires
  input wire logic [PORT_W-1:0] portCOut,
  input wire logic [PORT_W-1:0] portCOeN,
  output logic [PORT_W-1:0] portCPins,
  // strobes
  input wire logic outputStrobe,
  output logic inputStrobe
);
  logic [PORT_W-1:0] extData = 8'h00;
  logic extDrive = 1'b0;
  logic [PORT_W-1:0] lastPins = 8'h00;
  initial inputStrobe = 1'b1;
  // ------------------------------------------------------------
  // wire resolution
  // ------------------------------------------------------------
  // no pull on port c: an undriven line toggles so a held value never passes
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      portCPins[i] = !portCOeN[i] ? portCOut[i] : (extDrive ? extData[i] : ~lastPins[i]);
    end
  end
  always @(posedge core_clk) lastPins <= portCPins;
  // ------------------------------------------------------------
  // strobe sequences
  // ------------------------------------------------------------
  task automatic setStrobe(input logic lvl);
    @(posedge core_clk);
    inputStrobe <= lvl;
  endtask
  // data first, then the selected edge
  task automatic sendData(input logic [PORT_W-1:0] d, input logic rising);
    @(posedge core_clk);
    inputStrobe <= ~rising;
    repeat (2) @(posedge core_clk);
    extData <= d;
    extDrive <= 1'b1;
    repeat (2) @(posedge core_clk);
    inputStrobe <= rising;
    repeat (2) @(posedge core_clk);
    extDrive <= 1'b0;
  endtask
  // raise strobe, read the lines, acknowledge with a falling edge
  task automatic ackOutput(input logic actLvl, output logic [PORT_W-1:0] seen);
    while (outputStrobe !== actLvl) @(negedge core_clk);
    @(posedge core_clk);
    inputStrobe <= 1'b1;
    repeat (3) @(negedge core_clk);
    seen = portCPins;
    @(posedge core_clk);
    inputStrobe <= 1'b0;
  endtask
endmodule // sph_ext_system

// ---- testbench/sph_parallel_io_tb.sv ----
// self-checking testbench of the strobed handshake parallel port
`timescale 1ns/10ps
module sph_parallel_io_tb import sph_pkg::*;;
  localparam int PCYC = 4;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [DATA_W-1:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [DATA_W-1:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic inputStrobe;
  logic outputStrobe;
  logic [PORT_W-1:0] portBOut;
  logic [PORT_W-1:0] portCPins;
  logic [PORT_W-1:0] portCOut;
  logic [PORT_W-1:0] portCOeN;
  logic irq;
  int errors = 0;
  int checkCount = 0;
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  sph_parallel_io #(.PULSE_CYC(PCYC)) sph_parallel_io_inst (.core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .inputStrobe, .outputStrobe, .portBOut, .portCIn(portCPins), .portCOut, .portCOeN, .irq);
  sph_ext_system sph_ext_system_inst (.core_clk, .portCOut, .portCOeN, .portCPins, .outputStrobe, .inputStrobe);
  // ------------------------------------------------------------
  // compare, bus and report tasks
  // ------------------------------------------------------------
  task automatic checkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic checkResp(input string what, input logic [1:0] exp, input logic [1:0] got);
    checkCount++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // address and data are released one by one as each is taken
  task automatic axiWrite(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aT;
    logic wT;
    logic bT;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aT = 1'b0;
    wT = 1'b0;
    bT = 1'b0;
    while (!(aT && wT)) begin
      @(negedge core_clk);
      if (s_axi_awvalid && s_axi_awready) aT = 1'b1;
      if (s_axi_wvalid && s_axi_wready) wT = 1'b1;
      @(posedge core_clk);
      if (aT) s_axi_awvalid <= 1'b0;
      if (wT) s_axi_wvalid <= 1'b0;
    end
    while (!bT) begin
      @(negedge core_clk);
      bT = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge core_clk);
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic axiRead(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic done;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge core_clk);
      done = s_axi_arready;
      @(posedge core_clk);
    end
    s_axi_arvalid <= 1'b0;
    done = 1'b0;
    while (!done) begin
      @(negedge core_clk);
      done = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge core_clk);
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [1:0] r;
    axiWrite(a, d, r);
    checkResp("write response", RESP_OKAY, r);
  endtask
  task automatic rdChk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axiRead(a, d, r);
    checkResp("read response", RESP_OKAY, r);
    checkVal(what, exp, d);
  endtask
  // counts cycles with the output strobe at a level over a fixed window
  task automatic countActive(input logic lvl, output int c);
    c = 0;
    repeat (40) begin
      @(negedge core_clk);
      if (outputStrobe === lvl) c++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic testReset();
    rdChk("control reset", OFS_CTRL, 32'h0000_0000);
    rdChk("mode reset", OFS_MODE, 32'h0000_0003);
    rdChk("mask reset", OFS_MASK, 32'h0000_0000);
    @(negedge core_clk);
    checkVal("strobe idle", 32'h1, {31'h0, outputStrobe});
    checkVal("port c enables", 32'h0000_00ff, {24'h0, portCOeN});
  endtask
  task automatic testSimple();
    int c;
    wr(OFS_MODE, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0040);
    fork
      wr(OFS_PORT_B_DATA, 32'h0000_0081);
      countActive(1'b0, c);
      sph_ext_system_inst.sendData(8'h5a, 1'b0);
    join
    checkVal("pulse length", PCYC, c);
    checkVal("port b", 32'h0000_0081, {24'h0, portBOut});
    checkVal("irq flag", 32'h1, {31'h0, irq});
    wr(OFS_MODE, 32'h0000_0003);
    checkVal("irq cpu masked", 32'h0, {31'h0, irq});
    wr(OFS_MODE, 32'h0000_0001);
    rdChk("control flag", OFS_CTRL, 32'h0000_00c0);
    rdChk("capture latch", OFS_LATCH, 32'h0000_005a);
    rdChk("control cleared", OFS_CTRL, 32'h0000_0040);
    checkVal("irq cleared", 32'h0, {31'h0, irq});
    rdChk("status events", OFS_STAT, 32'h0000_0003);
    wr(OFS_MASK, 32'h0000_0001);
    checkVal("irq masked event", 32'h1, {31'h0, irq});
    wr(OFS_STAT, 32'h0000_0003);
    checkVal("irq after w1c", 32'h0, {31'h0, irq});
    rdChk("status cleared", OFS_STAT, 32'h0000_0000);
    wr(OFS_MASK, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    fork
      wr(OFS_PORT_B_DATA, 32'h0000_003c);
      countActive(1'b1, c);
    join
    checkVal("inverted pulse", PCYC, c);
    wr(OFS_MODE, 32'h0000_0000);
    fork
      wr(OFS_PORT_B_DATA, 32'h0000_0042);
      countActive(1'b1, c);
    join
    checkVal("no strobe outside single chip", 0, c);
    wr(OFS_MODE, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0002);
    sph_ext_system_inst.sendData(8'h96, 1'b1);
    rdChk("rising flag", OFS_CTRL, 32'h0000_0082);
    rdChk("rising latch", OFS_LATCH, 32'h0000_0096);
  endtask
  task automatic testInputHs();
    wr(OFS_CTRL, 32'h0000_0010);
    @(negedge core_clk);
    checkVal("ready", 32'h0, {31'h0, outputStrobe});
    wr(OFS_DIR, 32'h0000_000f);
    wr(OFS_PORTC, 32'h0000_0005);
    @(negedge core_clk);
    checkVal("mixed enables", 32'h0000_00f0, {24'h0, portCOeN});
    checkVal("static outputs", 32'h5, {28'h0, portCOut[3:0]});
    wr(OFS_CTRL, 32'h0000_0030);
    @(negedge core_clk);
    checkVal("open drain enables", 32'h0000_00f5, {24'h0, portCOeN});
    wr(OFS_CTRL, 32'h0000_0010);
    sph_ext_system_inst.sendData(8'hc3, 1'b0);
    @(negedge core_clk);
    checkVal("ready negated", 32'h1, {31'h0, outputStrobe});
    rdChk("mixed capture", OFS_LATCH, 32'h0000_00c5);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    checkVal("ready again", 32'h0, {31'h0, outputStrobe});
    wr(OFS_DIR, 32'h0000_0000);
  endtask
  task automatic testOutputHs();
    logic [PORT_W-1:0] seen;
    int c;
    sph_ext_system_inst.setStrobe(1'b0);
    wr(OFS_CTRL, 32'h0000_0018);
    wr(OFS_LATCH, 32'h0000_00a5);
    @(negedge core_clk);
    checkVal("data ready", 32'h0, {31'h0, outputStrobe});
    checkVal("three-state idle", 32'h0000_00ff, {24'h0, portCOeN});
    sph_ext_system_inst.ackOutput(1'b0, seen);
    checkVal("driven lines", 32'h0000_00a5, {24'h0, seen});
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    checkVal("interlock released", 32'h1, {31'h0, outputStrobe});
    checkVal("lines released", 32'h0000_00ff, {24'h0, portCOeN});
    rdChk("output flag", OFS_CTRL, 32'h0000_0098);
    wr(OFS_CTRL, 32'h0000_001c);
    fork
      wr(OFS_LATCH, 32'h0000_005a);
      countActive(1'b0, c);
    join
    checkVal("handshake pulse", PCYC, c);
    rdChk("flag cleared by write", OFS_CTRL, 32'h0000_001c);
  endtask
  task automatic testUnmapped();
    logic [31:0] d;
    logic [1:0] r;
    axiWrite(8'h20, 32'h0000_0001, r);
    checkResp("unmapped write", RESP_SLVERR, r);
    axiRead(8'h20, d, r);
    checkResp("unmapped read", RESP_SLVERR, r);
  endtask
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    testReset();
    testSimple();
    testInputHs();
    testOutputHs();
    testUnmapped();
    summarize();
  end
  // the whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    summarize();
  end
endmodule // sph_parallel_io_tb
